/* rtl/asc_ctrl.sv */
// asc_ctrl: host controller for an asynchronous 512K x 32 ecc memory
// assumes one 250 MHz clock; the testbench resolves the data wires
// How it works
// - select active: primary low, secondary high
// - write needs select, strobe low, lane low
// - data valid setup before end, hold zero
// - address stable setup before write end
// - address fixed from start through write end
// - lane selects low setup before write end
// - strobe pulse covers float plus setup
// - no data drive while device may drive
// - strobe stays high during reads
`timescale 1ns/1ps
module asc_ctrl
  import asc_pkg::*;
(
  // clock and reset
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_resetn,
  // user request
  input  wire logic                       i_req,
  input  wire logic                       i_we,
  input  wire logic [asc_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [asc_pkg::DATA_W-1:0] i_wdata,
  input  wire logic [asc_pkg::LANE_W-1:0] i_lanes,
  output logic                            o_ready,
  // user answer
  output logic                            o_done,
  output logic [asc_pkg::DATA_W-1:0]      o_rdata,
  output logic                            o_corrected,
  // memory pins
  output logic                            o_primary_select_n,
  output logic                            o_secondary_select,
  output logic                            o_write_strobe_n,
  output logic                            o_output_gate_n,
  output logic [asc_pkg::LANE_W-1:0]      o_lane_select_n,
  output logic [asc_pkg::ADDR_W-1:0]      o_addr,
  output logic [asc_pkg::DATA_W-1:0]      o_data,
  output logic                            o_data_oe,
  input  wire logic [asc_pkg::DATA_W-1:0] i_data,
  input  wire logic                       i_error_flag
);
  import asc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  asc_state_t       state;
  asc_state_t       next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             is_wr;
  logic [DATA_W-1:0] data_sync;
  logic             err_sync;

  // pin inputs through three stages
  asc_sync #(.W(DATA_W + 1)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_d       ({i_error_flag, i_data}),
    .o_q       ({err_sync, data_sync})
  );

  ////////////////////////////////////////////////////////////////////////
  // decode
  wire cnt_zero  = (cnt == '0);
  wire take      = i_req && (state == ASC_IDLE);
  wire lanes_any = |i_lanes;
  wire start     = take && lanes_any;
  // sync latency, so sampled data is no older than the wait
  wire [CNT_W-1:0] rd_load = RD_WAIT + CNT_W'(3);
  assign o_ready = (state == ASC_IDLE);

  // next state
  always_comb begin
    next_state = state;
    next_cnt   = cnt_zero ? cnt : cnt - CNT_W'(1);
    case (state)
      ASC_IDLE: begin
        if (start) begin
          next_state = i_we ? ASC_WR : ASC_RD;
          next_cnt   = i_we ? WR_PULSE : rd_load;
        end
      end
      ASC_RD: begin
        if (cnt_zero) begin
          next_state = ASC_TURN;
          next_cnt   = TURN_W;
        end
      end
      ASC_WR: begin
        if (cnt_zero) begin
          next_state = ASC_END;
          next_cnt   = CNT_W'(1);
        end
      end
      ASC_END: begin
        if (cnt_zero) begin
          next_state = ASC_IDLE;
        end
      end
      ASC_TURN: begin
        if (cnt_zero) begin
          next_state = ASC_IDLE;
        end
      end
      default: begin
        next_state = ASC_IDLE;
        next_cnt   = '0;
      end
    endcase
  end

  // state and counter
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      state <= ASC_IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin decode: what the memory side shows in the next cycle
  wire sel_drop = (next_state == ASC_IDLE) || (next_state == ASC_TURN);
  wire wr_next  = (next_state == ASC_WR);
  wire rd_next  = (next_state == ASC_RD);
  wire wr_hold  = (next_state == ASC_END) && is_wr;
  wire op_end   = (state == ASC_RD || state == ASC_WR) && cnt_zero;
  wire rd_last  = (state == ASC_RD) && cnt_zero;

  // request latch: address and data fixed for the whole cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      is_wr  <= 1'b0;
      o_addr <= '0;
      o_data <= '0;
    end else if (start) begin
      is_wr  <= i_we;
      o_addr <= i_addr;
      o_data <= i_wdata;
    end
  end

  // combined select: on at start, off for idle or turnaround
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_primary_select_n <= 1'b1;
      o_secondary_select <= 1'b0;
    end else if (start) begin
      o_primary_select_n <= 1'b0;
      o_secondary_select <= 1'b1;
    end else if (sel_drop) begin
      o_primary_select_n <= 1'b1;
      o_secondary_select <= 1'b0;
    end
  end

  // lane selects share the select window, so they never lead it
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_lane_select_n <= 4'hF;
    end else if (start) begin
      o_lane_select_n <= ~i_lanes;
    end else if (sel_drop) begin
      o_lane_select_n <= 4'hF;
    end
  end

  // write strobe low only in the write pulse, high in every read
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_write_strobe_n <= 1'b1;
    end else begin
      o_write_strobe_n <= !wr_next;
    end
  end

  // output gate low only in the read wait
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_output_gate_n <= 1'b1;
    end else begin
      o_output_gate_n <= !rd_next;
    end
  end

  // data drive only in writes with gate high: no contention
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_data_oe <= 1'b0;
    end else begin
      o_data_oe <= wr_next || wr_hold;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // done pulses at the end of either wait
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_done <= 1'b0;
    end else begin
      o_done <= op_end;
    end
  end

  // read answer captured at the end of the wait, held until the next
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_rdata     <= '0;
      o_corrected <= 1'b0;
    end else if (rd_last) begin
      o_rdata     <= data_sync;
      o_corrected <= err_sync;
    end
  end
endmodule

/* rtl/asc_pkg.sv */
// asc_pkg: constants for the asynchronous ecc memory host controller
// assumes a 250 MHz controller clock; all times in picoseconds
package asc_pkg;
  localparam int CLK_PERIOD_PS          = 4000;
  localparam int ADDR_W                 = 19;
  localparam int DATA_W                 = 32;
  localparam int LANE_W                 = 4;
  // speed grade select: 0 = 45 ns grade, 1 = 55 ns grade
  localparam bit GRADE_SLOW             = 1'b0;
  // printed times, ps
  localparam int ADDRESS_ACCESS_TIME_PS = GRADE_SLOW ? 55000 : 45000;
  localparam int SELECT_ACCESS_TIME_PS  = GRADE_SLOW ? 55000 : 45000;
  localparam int GATE_ACCESS_TIME_PS    = GRADE_SLOW ? 25000 : 22000;
  localparam int LANE_ACCESS_TIME_PS    = GRADE_SLOW ? 55000 : 45000;
  localparam int WRITE_DATA_SETUP_PS    = 25000;
  localparam int WRITE_DATA_HOLD_PS     = 0;
  localparam int ADDRESS_SETUP_TO_END_PS = GRADE_SLOW ? 40000 : 35000;
  localparam int ADDRESS_HOLD_AFTER_END_PS = 0;
  localparam int ADDRESS_SETUP_TO_START_PS = 0;
  localparam int LANE_LOW_TO_END_PS     = GRADE_SLOW ? 40000 : 35000;
  localparam int STROBE_FLOAT_DELAY_PS  = GRADE_SLOW ? 20000 : 18000;
  localparam int GATE_FLOAT_DELAY_PS    = 18000;
  localparam int CYCLE_TIME_PS          = GRADE_SLOW ? 55000 : 45000;
  // cycle counts, rounded up
  function automatic int cyc(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int RD_WAIT_PS = (ADDRESS_ACCESS_TIME_PS > SELECT_ACCESS_TIME_PS)
                              ? ADDRESS_ACCESS_TIME_PS : SELECT_ACCESS_TIME_PS;
  localparam int RD_WAIT_CYC  = cyc(RD_WAIT_PS);
  localparam int WR_PULSE_PS0 = STROBE_FLOAT_DELAY_PS + WRITE_DATA_SETUP_PS;
  localparam int WR_PULSE_PS  = (WR_PULSE_PS0 > ADDRESS_SETUP_TO_END_PS)
                                ? WR_PULSE_PS0 : ADDRESS_SETUP_TO_END_PS;
  localparam int WR_PULSE_CYC = cyc(WR_PULSE_PS);
  localparam int FLOAT_CYC    = cyc(STROBE_FLOAT_DELAY_PS);
  localparam int TURN_CYC     = cyc(GATE_FLOAT_DELAY_PS);
  localparam int CNT_W        = 6;
  localparam logic [CNT_W-1:0] RD_WAIT  = CNT_W'(RD_WAIT_CYC);
  localparam logic [CNT_W-1:0] WR_PULSE = CNT_W'(WR_PULSE_CYC);
  localparam logic [CNT_W-1:0] FLOAT_W  = CNT_W'(FLOAT_CYC);
  localparam logic [CNT_W-1:0] TURN_W   = CNT_W'(TURN_CYC);
  // controller states
  typedef enum logic [4:0] {
    ASC_IDLE  = 5'h01,
    ASC_RD    = 5'h02,
    ASC_WR    = 5'h04,
    ASC_END   = 5'h08,
    ASC_TURN  = 5'h10
  } asc_state_t;
endpackage

/* rtl/asc_sync.sv */
// asc_sync: three-stage synchroniser for pin inputs
// assumes the input is asynchronous to i_ref_clk
`timescale 1ns/1ps
module asc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_resetn,
  // data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // stage chain; value accepted when last two agree
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      o_q <= '0;
    end else begin
      s1 <= i_d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        o_q <= s3;
      end
    end
  end
endmodule

/* tb/asc_ctrl_monitor.sv */
// asc_ctrl_monitor: memory pin timing checks
// assumes bind onto asc_ctrl, 4 ns clock
`timescale 1ns/1ps
module asc_ctrl_monitor (
  // clock and reset
  input wire logic                       i_ref_clk,
  input wire logic                       i_resetn,
  // memory pins
  input wire logic                       o_primary_select_n,
  input wire logic                       o_secondary_select,
  input wire logic                       o_write_strobe_n,
  input wire logic                       o_output_gate_n,
  input wire logic [asc_pkg::LANE_W-1:0] o_lane_select_n,
  input wire logic [asc_pkg::ADDR_W-1:0] o_addr,
  input wire logic [asc_pkg::DATA_W-1:0] o_data,
  input wire logic                       o_data_oe
);
  import asc_pkg::*;
  wire logic sel;
  // combined select
  assign sel = !o_primary_select_n && o_secondary_select;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // strobe low 11 cycles, then the write-ending edge
  sequence s_low;
    (!o_write_strobe_n)[*8] ##1 (!o_write_strobe_n)[*3];
  endsequence
  sequence s_end;
    $rose(o_write_strobe_n) && sel;
  endsequence
  a_read_strobe_hi: assert property (
    !o_output_gate_n |-> o_write_strobe_n) else $error("strobe in read");
  a_no_contend: assert property (
    o_data_oe |-> o_output_gate_n && $past(o_output_gate_n, 5))
    else $error("data drive too soon");
  a_write_sel: assert property (
    !o_write_strobe_n |-> sel && o_lane_select_n != 4'hF)
    else $error("write unselected");
  a_strobe_width: assert property (
    $fell(o_write_strobe_n) |-> s_low) else $error("strobe short");
  a_addr_fixed: assert property (
    !o_write_strobe_n |=> $stable(o_addr)) else $error("addr moved");
  a_addr_setup: assert property (
    s_end |-> $past(o_addr, 9) == o_addr) else $error("addr setup");
  a_lane_setup: assert property (
    s_end |-> $past(o_lane_select_n, 9) == o_lane_select_n)
    else $error("lane setup");
  a_data_setup: assert property (
    s_end |-> $past(o_data_oe, 7) && $past(o_data, 7) == o_data
    && o_data_oe) else $error("data setup");
endmodule
bind asc_ctrl asc_ctrl_monitor u_asc_ctrl_monitor (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
  .o_primary_select_n(o_primary_select_n),
  .o_secondary_select(o_secondary_select),
  .o_write_strobe_n(o_write_strobe_n), .o_output_gate_n(o_output_gate_n),
  .o_lane_select_n(o_lane_select_n), .o_addr(o_addr), .o_data(o_data),
  .o_data_oe(o_data_oe));

/* tb/asc_ctrl_tb_top.sv */
// asc_ctrl_tb_top: directed bench for the memory host controller
// assumes the behavioural memory on the far side
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  error_cnt++; $display("wrong value %0t %h %h", $time, g, e); end end
module asc_ctrl_tb_top;
  import asc_pkg::*;
  logic i_ref_clk = 1'b0, i_resetn = 1'b0, i_req = 1'b0, i_we = 1'b0;
  logic [18:0] i_addr = 19'h0, o_addr, bad = 19'h00123;
  logic [31:0] i_wdata = 32'h0, o_rdata, o_data, rd, bus, exp_w;
  logic [3:0]  i_lanes = 4'h0, o_lane_select_n;
  logic o_ready, o_done, o_corrected, o_data_oe, err, slow = 1'b0;
  logic [8:0]  idle_pins;
  logic o_primary_select_n, o_secondary_select;
  logic o_write_strobe_n, o_output_gate_n;
  int   error_cnt = 0, check_count = 0;
  // clock and data wire resolution
  always #2 i_ref_clk = ~i_ref_clk;
  assign bus = o_data_oe ? o_data : rd;
  asc_ctrl u_asc_ctrl (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_req(i_req), .i_we(i_we), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_lanes(i_lanes), .o_ready(o_ready), .o_done(o_done),
    .o_rdata(o_rdata), .o_corrected(o_corrected),
    .o_primary_select_n(o_primary_select_n),
    .o_secondary_select(o_secondary_select),
    .o_write_strobe_n(o_write_strobe_n), .o_output_gate_n(o_output_gate_n),
    .o_lane_select_n(o_lane_select_n), .o_addr(o_addr), .o_data(o_data),
    .o_data_oe(o_data_oe), .i_data(bus), .i_error_flag(err));
  asc_sram_model u_asc_sram_model (.i_primary_select_n(o_primary_select_n),
    .i_secondary_select(o_secondary_select), .i_we_n(o_write_strobe_n),
    .i_oe_n(o_output_gate_n), .i_lane_n(o_lane_select_n), .i_addr(o_addr),
    .i_data(o_data), .o_data(rd), .o_err(err), .i_slow(slow), .i_bad(bad));
  task results;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one request, bounded wait for done
  task op(input logic we, input logic [18:0] a, input logic [31:0] d,
          input logic [3:0] ln, input logic want);
    int n;
    n = 0;
    while (o_ready !== 1'b1 && n < 20) begin
      @(negedge i_ref_clk);
      n++;
    end
    `CHK(o_ready, 1'b1)
    if (o_ready !== 1'b1) results;
    @(posedge i_ref_clk);
    i_req <= 1'b1;
    i_we <= we;
    i_addr <= a;
    i_wdata <= d;
    i_lanes <= ln;
    @(posedge i_ref_clk);
    i_req <= 1'b0;
    n = 0;
    do begin
      @(negedge i_ref_clk);
      n++;
    end while (o_done !== 1'b1 && n < 40);
    `CHK(o_done, want)
    if (o_done !== want) results;
  endtask
  task t_reset;
    @(posedge i_ref_clk);
    i_resetn <= 1'b0;
    repeat (10) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    @(negedge i_ref_clk);
    idle_pins = {o_primary_select_n, o_secondary_select, o_write_strobe_n,
                 o_output_gate_n, o_lane_select_n, o_data_oe};
    `CHK(idle_pins, 9'h17E)
    $display("reset test done");
  endtask
  // full word, each lane alone over it, then one-lane read
  task t_lanes;
    exp_w = 32'hA5C30F96;
    op(1'b1, 19'h0004A, exp_w, 4'hF, 1'b1);
    for (int i = 0; i < 4; i++) begin
      op(1'b1, 19'h0004A, {4{8'h5A ^ 8'(i)}}, 4'(1 << i), 1'b1);
      exp_w[8*i+:8] = 8'h5A ^ 8'(i);
      op(1'b0, 19'h0004A, 32'h0, 4'hF, 1'b1);
      `CHK(o_rdata, exp_w)
    end
    op(1'b0, 19'h0004A, 32'h0, 4'h4, 1'b1);
    `CHK(o_rdata[23:16], exp_w[23:16])
    $display("lane test done");
  endtask
  // corrected flag per address, prompt and slow memory
  task t_err;
    op(1'b1, bad, 32'hDEADBEEF, 4'hF, 1'b1);
    for (int s = 0; s < 2; s++) begin
      slow <= 1'(s);
      op(1'b0, bad, 32'h0, 4'hF, 1'b1);
      `CHK({o_corrected, o_rdata}, {1'b1, 32'hDEADBEEF})
      op(1'b0, 19'h0004A, 32'h0, 4'hF, 1'b1);
      `CHK({o_corrected, o_rdata}, {1'b0, exp_w})
    end
    $display("flag test done");
  endtask
  // zero lanes: no cycle, word untouched
  task t_refuse;
    op(1'b1, 19'h0004A, 32'h0, 4'h0, 1'b0);
    `CHK(o_primary_select_n, 1'b1)
    op(1'b0, 19'h0004A, 32'h0, 4'hF, 1'b1);
    `CHK(o_rdata, exp_w)
    $display("refuse test done");
  endtask
  initial begin
    t_reset;
    t_lanes;
    t_err;
    t_reset;
    t_refuse;
    results;
  end
endmodule

/* tb/asc_sram_model.sv */
// asc_sram_model: behavioural ecc memory on the pin side
// assumes the bench resolves the shared data wires
`timescale 1ns/1ps
module asc_sram_model (
  // memory pins
  input  wire logic        i_primary_select_n,
  input  wire logic        i_secondary_select,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  input  wire logic [3:0]  i_lane_n,
  input  wire logic [18:0] i_addr,
  input  wire logic [31:0] i_data,
  output logic      [31:0] o_data,
  output logic             o_err,
  // test controls
  input  wire logic        i_slow,
  input  wire logic [18:0] i_bad
);
  logic [31:0] mem [0:19'h7FFFF];
  logic        on;
  logic        cs;
  // drive only when selected, gated, not writing
  assign cs = !i_primary_select_n && i_secondary_select;
  assign on = cs && !i_oe_n && i_we_n;
  // strobe rise ends the write, lanes pick bytes
  always @(posedge i_we_n) begin
    if (cs) begin
      for (int i = 0; i < 4; i++)
        if (!i_lane_n[i]) mem[i_addr][8*i+:8] = i_data[8*i+:8];
    end
  end
  // old word held, then released as a new pattern, then new word
  initial begin
    {o_data, o_err} = 33'h0;
    forever begin
      @(on, i_addr, i_lane_n);
      #10;
      {o_data, o_err} = ~{o_data, o_err};
      #(i_slow ? 35 : 5);
      if (on) begin
        o_err = (i_addr == i_bad);
        for (int i = 0; i < 4; i++)
          if (!i_lane_n[i]) o_data[8*i+:8] = mem[i_addr][8*i+:8];
      end
    end
  end
endmodule
